//--- inc/blpf_defines.svh
`ifndef BLPF_DEFINES_SVH
`define BLPF_DEFINES_SVH

// ****************************************************************
// Register offsets on the serial port
// ****************************************************************
`define BLPF_ADDR_PROT 7'h03
`define BLPF_ADDR_SHORT 7'h64
`define BLPF_ADDR_CURON_LO 7'h01
`define BLPF_ADDR_CURON_HI 7'h02
`define BLPF_ADDR_STATUS 7'h05
`define BLPF_ADDR_FLAG_LO 7'h06
`define BLPF_ADDR_FLAG_HI 7'h07

// ****************************************************************
// Field positions
// ****************************************************************
`define BLPF_PROT_UV_AUTO_OFF 4
`define BLPF_SHORT_THR_MSB 2
`define BLPF_SHORT_THR_LSB 0
`define BLPF_SHORT_EN 3
`define BLPF_SHORT_AUTO_OFF 4

// ****************************************************************
// Reset values
// ****************************************************************
`define BLPF_PROT_RESET 8'h1f
`define BLPF_SHORT_RESET 8'h18
`define BLPF_CURON_RESET 16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define BLPF_CLK_KHZ 10000
`define BLPF_OSC_KHZ 8000
`define BLPF_SHORT_MIN_US 10
`define BLPF_SHORT_MIN_CYC ((`BLPF_SHORT_MIN_US * `BLPF_CLK_KHZ + 999) / 1000)
`define BLPF_CMD_BITS 16

`endif

//--- inc/blpf_pkg.sv
package blpf_pkg;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef logic [15:0] blpf_chan_t;
	typedef logic [6:0] blpf_addr_t;

	typedef enum logic [1:0] {
		PWR_SHUTDOWN = 2'b00,
		PWR_STANDBY = 2'b01,
		PWR_LOW_SUPPLY = 2'b10
	} blpf_pwr_t;

endpackage

//--- verilog/blpf_pulse_gen.sv
module blpf_pulse_gen #(
	parameter int DW = 14
) (
	// Generator clock and raw reset
	input wire logic gen_clk_i,
	input wire logic reset_n_i,
	// Frame sync pin and brightness
	input wire logic frame_sync_i,
	input wire logic [DW-1:0] duty_i,
	// Channel enables from the control domain
	input wire blpf_pkg::blpf_chan_t chan_en_i,
	// Channel drive
	output blpf_pkg::blpf_chan_t channel_on_o
);
	import blpf_pkg::*;

	localparam int SW = 1 + DW + 16;

	logic rst_meta_q;
	logic rst_n_q;
	logic [SW-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic frame_prev_q;
	logic [DW-1:0] cnt_q, cnt_d;
	blpf_chan_t on_d;
	logic frame_f;
	logic [DW-1:0] duty_f;
	blpf_chan_t en_f;

	// ****************************************************************
	// Reset release in this domain
	// ****************************************************************
	always_ff @(posedge gen_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// sync into generator clock
	always_comb begin
		filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
	end

	assign frame_f = filt_q[SW-1];
	assign duty_f = filt_q[SW-2 -: DW];
	assign en_f = filt_q[15:0];

	// ****************************************************************
	// Period counter and channel drive
	// ****************************************************************
	// The clock here is line_sync_clk_i, wired straight to gen_clk_i by
	// blpf_top; this logic only needs a running edge.
	always_comb begin
		if (frame_f && !frame_prev_q) begin
			cnt_d = '0;
		end else begin
			cnt_d = cnt_q + DW'(1);
		end
		for (int i = 0; i < 16; i++) begin
			on_d[i] = en_f[i] && (cnt_q < duty_f);
		end
	end

	always_ff @(posedge gen_clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			filt_q <= '0;
			frame_prev_q <= 1'b0;
			cnt_q <= '0;
			channel_on_o <= '0;
		end else begin
			s1_q <= {frame_sync_i, duty_i, chan_en_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			frame_prev_q <= frame_f;
			cnt_q <= cnt_d;
			channel_on_o <= on_d;
		end
	end

endmodule

//--- verilog/blpf_top.sv
// Function
// - supply above power-on level enters standby
// - auto-off: warning level clears channel enables
// - auto-off clear: run until lockout, then reset
// - lockout level always enters shutdown
// - auto-off bit is bit 4 at 03h
// - three-bit code selects short threshold
// - short judged only after 10 us on-time
// - oscillator timebase drives generators otherwise (not in this logic: u_gen always runs on line_sync_clk_i)
// - frame sync resets all generators
// - line sync clocks generator counters
// - fault pin open-drain, pulled low on fault
// - data out driven only during reads
// - bit 3 at 64h enables short detection
// - short plus auto-off turns channel off
`include "blpf_defines.svh"

module blpf_top #(
	parameter int DW = 14
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Pulse generator timebase and frame sync
	input wire logic line_sync_clk_i,
	input wire logic frame_sync_i,
	input wire logic [DW-1:0] duty_i,
	// Supply comparators
	input wire logic supply_above_por_i,
	input wire logic supply_above_warn_i,
	input wire logic supply_above_lockout_i,
	// Channel drain comparators and drive
	input wire blpf_pkg::blpf_chan_t short_cmp_i,
	output blpf_pkg::blpf_chan_t channel_on_o,
	output logic [2:0] short_threshold_sel_o,
	// Serial port
	input wire logic serial_select_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_data_in_i,
	output logic serial_data_out_o,
	output logic serial_data_out_oe_o,
	// Fault pin and state
	output logic fault_o,
	output logic fault_oe_o,
	output blpf_pkg::blpf_pwr_t power_state_o
);
	import blpf_pkg::*;

	localparam int PW = 16 + 16 + 6;
	localparam int MW = $clog2(`BLPF_SHORT_MIN_CYC + 1);
	localparam logic [MW-1:0] MIN_CYC = MW'(`BLPF_SHORT_MIN_CYC);
	localparam int BW = $clog2(`BLPF_CMD_BITS + 1);
	// Stages reset to the idle pin levels, so release makes no false edge.
	localparam logic [PW-1:0] IDLE = {32'h00000000, 6'h0c};

	logic rst_meta_q;
	logic rst_n_q;
	logic [PW-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	blpf_chan_t short_f, on_f;
	logic por_f, warn_f, lock_f, sel_n_f, sclk_f, din_f;
	wire blpf_chan_t det;
	blpf_chan_t chan_on_link;

	blpf_pwr_t state_q, state_d;
	logic [7:0] prot_q, prot_d;
	logic [7:0] short_q, short_d;
	blpf_chan_t cur_on_q, cur_on_d;
	blpf_chan_t flag_q, flag_d;
	blpf_chan_t off_q, off_d;
	blpf_chan_t chan_en_q, chan_en_d;
	logic fault_oe_d;

	logic sclk_prev_q;
	logic [BW-1:0] bit_q, bit_d;
	logic [15:0] sh_q, sh_d;
	logic rd_q, rd_d;
	blpf_addr_t addr_q, addr_d;
	logic [7:0] rdat_q, rdat_d;
	logic dout_d, dout_oe_d;
	logic rise, fall, wr_en;
	logic [7:0] wdat;
	blpf_chan_t clr;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	// A bit changes only once stages two and three agree, which also
	// rejects single-cycle glitches on the comparators.
	// three-stage input filter
	always_comb begin
		filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			s1_q <= IDLE;
			s2_q <= IDLE;
			s3_q <= IDLE;
			filt_q <= IDLE;
		end else begin
			s1_q <= {chan_on_link, short_cmp_i, supply_above_por_i,
				supply_above_warn_i, supply_above_lockout_i,
				serial_select_n_i, serial_clk_i, serial_data_in_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	assign on_f = filt_q[37:22];
	assign short_f = filt_q[21:6];
	assign por_f = filt_q[5];
	assign warn_f = filt_q[4];
	assign lock_f = filt_q[3];
	assign sel_n_f = filt_q[2];
	assign sclk_f = filt_q[1];
	assign din_f = filt_q[0];

	// ****************************************************************
	// Short detection per channel
	// ****************************************************************
	// On-time is measured on the returned drive level, so it already
	// includes the crossing delay; pulses a few cycles over the minimum
	// may be missed, never ones under it judged.
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_ch
			logic [MW-1:0] cnt_q, cnt_d;
			always_comb begin
				if (!on_f[gi]) begin
					cnt_d = '0;
				end else if (cnt_q != MIN_CYC) begin
					cnt_d = cnt_q + MW'(1);
				end else begin
					cnt_d = cnt_q;
				end
			end
			// A drive level still returning after shutdown sets no flag.
			// detection gated by enable
			assign det[gi] = short_q[`BLPF_SHORT_EN] && on_f[gi] &&
				(cnt_q == MIN_CYC) && short_f[gi] &&
				(state_q != PWR_SHUTDOWN);
			always_ff @(posedge clk_i or negedge rst_n_q) begin
				if (!rst_n_q) begin
					cnt_q <= '0;
				end else begin
					cnt_q <= cnt_d;
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Register read decode
	// ****************************************************************
	function automatic logic [7:0] reg_read(input blpf_addr_t a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`BLPF_ADDR_PROT: r = prot_q;
			`BLPF_ADDR_SHORT: r = short_q;
			`BLPF_ADDR_CURON_LO: r = cur_on_q[7:0];
			`BLPF_ADDR_CURON_HI: r = cur_on_q[15:8];
			`BLPF_ADDR_STATUS: r = {5'h00, fault_oe_o, state_q};
			`BLPF_ADDR_FLAG_LO: r = flag_q[7:0];
			`BLPF_ADDR_FLAG_HI: r = flag_q[15:8];
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ****************************************************************
	// Serial port
	// ****************************************************************
	// Mode 0, 16 bits MSB first: read flag, 7-bit address, 8-bit data.
	// The serial clock is oversampled, so it must stay below a quarter
	// of the system clock.
	assign rise = sclk_f && !sclk_prev_q && !sel_n_f;
	assign fall = !sclk_f && sclk_prev_q && !sel_n_f;

	always_comb begin
		bit_d = bit_q;
		sh_d = sh_q;
		rd_d = rd_q;
		addr_d = addr_q;
		rdat_d = rdat_q;
		dout_d = serial_data_out_o;
		wr_en = 1'b0;
		wdat = sh_q[7:0];
		if (sel_n_f) begin
			bit_d = '0;
			rd_d = 1'b0;
		end else if (rise && bit_q != BW'(`BLPF_CMD_BITS)) begin
			sh_d = {sh_q[14:0], din_f};
			bit_d = bit_q + BW'(1);
			if (bit_q == BW'(7)) begin
				rd_d = sh_d[7];
				addr_d = sh_d[6:0];
				rdat_d = reg_read(sh_d[6:0]);
			end
			if (bit_q == BW'(15) && !rd_q) begin
				wr_en = 1'b1;
				wdat = sh_d[7:0];
			end
		end else if (fall && rd_q && bit_q >= BW'(8) &&
				bit_q < BW'(`BLPF_CMD_BITS)) begin
			dout_d = rdat_q[7];
			rdat_d = {rdat_q[6:0], 1'b0};
		end
		if (state_q == PWR_SHUTDOWN) begin
			wr_en = 1'b0;
		end
		dout_oe_d = rd_q && !sel_n_f && bit_q >= BW'(8) &&
			state_q != PWR_SHUTDOWN;
	end

	// ****************************************************************
	// Power state and registers
	// ****************************************************************
	always_comb begin
		state_d = state_q;
		prot_d = prot_q;
		short_d = short_q;
		cur_on_d = cur_on_q;
		clr = '0;
		if (wr_en) begin
			case (addr_q)
				`BLPF_ADDR_PROT: prot_d = wdat;
				`BLPF_ADDR_SHORT: short_d = wdat;
				`BLPF_ADDR_CURON_LO: cur_on_d[7:0] = wdat;
				`BLPF_ADDR_CURON_HI: cur_on_d[15:8] = wdat;
				`BLPF_ADDR_FLAG_LO: clr[7:0] = wdat;
				`BLPF_ADDR_FLAG_HI: clr[15:8] = wdat;
				default: clr = '0;
			endcase
		end
		// Hardware set wins over a clear in the same cycle.
		flag_d = (flag_q & ~clr) | det;
		off_d = (off_q & ~clr) |
			(det & {16{short_q[`BLPF_SHORT_AUTO_OFF]}});
		unique case (state_q)
			PWR_SHUTDOWN: begin
				if (por_f && lock_f) begin
					state_d = PWR_STANDBY;
				end
			end
			PWR_STANDBY: begin
				if (!warn_f) begin
					state_d = PWR_LOW_SUPPLY;
					if (prot_q[`BLPF_PROT_UV_AUTO_OFF]) begin
						cur_on_d = `BLPF_CURON_RESET;
					end
				end
			end
			PWR_LOW_SUPPLY: begin
				if (warn_f) begin
					state_d = PWR_STANDBY;
				end
			end
			default: state_d = PWR_SHUTDOWN;
		endcase
		if (!lock_f && state_q != PWR_SHUTDOWN) begin
			state_d = PWR_SHUTDOWN;
			prot_d = `BLPF_PROT_RESET;
			short_d = `BLPF_SHORT_RESET;
			cur_on_d = `BLPF_CURON_RESET;
			flag_d = '0;
			off_d = '0;
		end
		chan_en_d = (state_q == PWR_SHUTDOWN) ? '0 : (cur_on_q & ~off_q);
		fault_oe_d = |flag_q;
	end

	always_ff @(posedge clk_i or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= PWR_SHUTDOWN;
			prot_q <= `BLPF_PROT_RESET;
			short_q <= `BLPF_SHORT_RESET;
			cur_on_q <= `BLPF_CURON_RESET;
			flag_q <= '0;
			off_q <= '0;
			chan_en_q <= '0;
			sclk_prev_q <= 1'b0;
			bit_q <= '0;
			sh_q <= '0;
			rd_q <= 1'b0;
			addr_q <= '0;
			rdat_q <= '0;
			serial_data_out_o <= 1'b0;
			serial_data_out_oe_o <= 1'b0;
			fault_o <= 1'b0;
			fault_oe_o <= 1'b0;
			power_state_o <= PWR_SHUTDOWN;
			short_threshold_sel_o <= 3'h0;
		end else begin
			state_q <= state_d;
			prot_q <= prot_d;
			short_q <= short_d;
			cur_on_q <= cur_on_d;
			flag_q <= flag_d;
			off_q <= off_d;
			chan_en_q <= chan_en_d;
			sclk_prev_q <= sclk_f;
			bit_q <= bit_d;
			sh_q <= sh_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			rdat_q <= rdat_d;
			serial_data_out_o <= dout_d;
			serial_data_out_oe_o <= dout_oe_d;
			fault_o <= 1'b0;
			fault_oe_o <= fault_oe_d;
			power_state_o <= state_d;
			short_threshold_sel_o <=
				short_d[`BLPF_SHORT_THR_MSB:`BLPF_SHORT_THR_LSB];
		end
	end

	// ****************************************************************
	// Pulse generators on the line sync clock
	// ****************************************************************
	blpf_pulse_gen #(
		.DW(DW)
	) u_gen (
		.gen_clk_i(line_sync_clk_i),
		.reset_n_i(reset_n_i),
		.frame_sync_i(frame_sync_i),
		.duty_i(duty_i),
		.chan_en_i(chan_en_q),
		.channel_on_o(chan_on_link)
	);

	assign channel_on_o = chan_on_link;

endmodule

//--- test/blpf_top_chk.sv
// ********
// Power state and pin checks
// ********
module blpf_top_chk (
	// Clock, reset and supplies
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic supply_above_por_i,
	input wire logic supply_above_warn_i,
	input wire logic supply_above_lockout_i,
	// Channels and pins
	input wire blpf_pkg::blpf_chan_t short_cmp_i,
	input wire blpf_pkg::blpf_chan_t channel_on_o,
	input wire logic serial_select_n_i,
	input wire logic serial_data_out_oe_o,
	input wire logic fault_o,
	input wire logic fault_oe_o,
	input wire blpf_pkg::blpf_pwr_t power_state_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import blpf_pkg::*;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	// Eight samples cover the three-flop filter plus the state edge.
	sequence s_good;
		(supply_above_por_i && supply_above_lockout_i)[*8];
	endsequence
	sequence s_off;
		(power_state_o == PWR_SHUTDOWN)[*8] ##1
			(power_state_o == PWR_SHUTDOWN)[*8];
	endsequence
	property p_up;
		s_good |-> ##[0:2] power_state_o != PWR_SHUTDOWN;
	endproperty
	a_up: assert property (p_up)
		else $error("no standby with supply good");
	property p_low;
		(supply_above_por_i && supply_above_lockout_i &&
			!supply_above_warn_i)[*8] |->
			##[0:2] power_state_o == PWR_LOW_SUPPLY;
	endproperty
	a_low: assert property (p_low)
		else $error("no low supply state");
	property p_lock;
		!supply_above_lockout_i[*8] |-> power_state_o == PWR_SHUTDOWN;
	endproperty
	a_lock: assert property (p_lock)
		else $error("no shutdown at lockout");
	property p_dark;
		s_off |-> channel_on_o == '0;
	endproperty
	a_dark: assert property (p_dark)
		else $error("channel lit in shutdown");
	property p_idle;
		serial_select_n_i[*8] |-> !serial_data_out_oe_o;
	endproperty
	a_idle: assert property (p_idle)
		else $error("data out driven while idle");
	property p_oe_off;
		$rose(serial_data_out_oe_o) |-> power_state_o != PWR_SHUTDOWN;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("read answered in shutdown");
	property p_drain;
		fault_oe_o |-> !fault_o;
	endproperty
	a_drain: assert property (p_drain)
		else $error("fault pin driven high");
	property p_short;
		$rose(fault_oe_o) |->
			($past(short_cmp_i, 5) | $past(short_cmp_i, 6)) != '0;
	endproperty
	a_short: assert property (p_short)
		else $error("fault without short");
	property p_quiet;
		(power_state_o == PWR_SHUTDOWN)[*2] |-> !fault_oe_o;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("fault pin held in shutdown");
endmodule
bind blpf_top blpf_top_chk u_chk (
	.clk_i, .reset_n_i, .supply_above_por_i,
	.supply_above_warn_i, .supply_above_lockout_i,
	.short_cmp_i, .channel_on_o, .serial_select_n_i,
	.serial_data_out_oe_o, .fault_o, .fault_oe_o, .power_state_o
);

//--- test/blpf_host_model.sv
// ********
// Timing controller and serial host
// ********
module blpf_host_model (
	// Pacing clock
	input wire logic clk_i,
	// Sync pins
	output logic line_sync_clk_o = 1'b0,
	output logic frame_sync_o = 1'b0,
	// Serial port
	output logic serial_select_n_o = 1'b1,
	output logic serial_clk_o = 1'b0,
	output logic serial_data_in_o = 1'b0,
	input wire logic serial_data_out_i,
	input wire logic serial_data_out_oe_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rel_q = 1'b0;
	logic dout_w;
	int n = 0;
	assign dout_w = serial_data_out_oe_i ? serial_data_out_i : rel_q;
	always @(posedge clk_i)
		rel_q <= ~rel_q;
	initial begin
		#13;
		forever #40 line_sync_clk_o = ~line_sync_clk_o;
	end
	always @(posedge line_sync_clk_o) begin
		n <= (n == 299) ? 0 : n + 1;
		frame_sync_o <= n < 64;
	end
	// Phases of 8 cycles let the filtered read bit settle first.
	task automatic xfer(input logic [15:0] w, output logic [7:0] r);
		r = 8'h00;
		@(posedge clk_i);
		#5 serial_select_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_clk_o = 1'b0;
			serial_data_in_o = w[i];
			repeat (8) @(posedge clk_i);
			#5 if (i < 8)
				r[i] = dout_w;
			serial_clk_o = 1'b1;
			repeat (8) @(posedge clk_i);
			#5;
		end
		serial_clk_o = 1'b0;
		serial_select_n_o = 1'b1;
		serial_data_in_o = 1'b0;
		repeat (8) @(posedge clk_i);
		#5;
	endtask
endmodule

//--- test/blpf_top_tb_top.sv
`include "blpf_defines.svh"
`define CMP(e, g) begin check_count++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD t=%0t exp=%h got=%h", $time, e, g); end end
module blpf_top_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import blpf_pkg::*;
	// The device does not time the power-on wait, so it is shortened.
	localparam int POR_WAIT = 200;
	localparam int LIMIT = 60000;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [13:0] duty_i = '1;
	logic por = 1'b0, warn = 1'b0, lock = 1'b0;
	blpf_chan_t short_cmp = '0;
	blpf_chan_t chan_on, mask;
	blpf_pwr_t state;
	logic [2:0] thr;
	logic ls_clk, fs, sel_n, sclk, din, dout, dout_oe, flt, flt_oe;
	logic [15:0] exp_q[$], got_q[$];
	logic [15:0] e_v, g_v;
	logic [7:0] rd;
	int miscompares = 0, check_count = 0, cycles = 0;
	wire fault_pin = flt_oe ? flt : 1'b1;
	initial forever #50 clk_i = ~clk_i;
	blpf_top #(.DW(14)) uut (
		.clk_i, .reset_n_i, .line_sync_clk_i(ls_clk),
		.frame_sync_i(fs), .duty_i, .supply_above_por_i(por),
		.supply_above_warn_i(warn), .supply_above_lockout_i(lock),
		.short_cmp_i(short_cmp), .channel_on_o(chan_on),
		.short_threshold_sel_o(thr), .serial_select_n_i(sel_n),
		.serial_clk_i(sclk), .serial_data_in_i(din),
		.serial_data_out_o(dout), .serial_data_out_oe_o(dout_oe),
		.fault_o(flt), .fault_oe_o(flt_oe), .power_state_o(state)
	);
	blpf_host_model h (
		.clk_i, .line_sync_clk_o(ls_clk), .frame_sync_o(fs),
		.serial_select_n_o(sel_n), .serial_clk_o(sclk),
		.serial_data_in_o(din), .serial_data_out_i(dout),
		.serial_data_out_oe_i(dout_oe)
	);
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#5;
	endtask
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		h.xfer({1'b0, a, d}, rd);
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] e);
		h.xfer({1'b1, a, 8'h00}, rd);
		chk({8'h00, e}, {8'h00, rd});
	endtask
	task automatic stop_test();
		wait (got_q.size() == 0);
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial forever begin
		wait (got_q.size() > 0);
		e_v = exp_q.pop_front();
		g_v = got_q.pop_front();
		`CMP(e_v, g_v)
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			stop_test();
		end
	end
	// ********
	// Main sequence
	// ********
	initial begin
		void'($urandom(32'h68da));
		mask = 16'h0001 << ($urandom % 16);
		tick(8);
		reset_n_i = 1'b1;
		tick(6);
		chk(16'(PWR_SHUTDOWN), 16'(state));
		{por, warn, lock} = 3'b111;
		tick(10);
		chk(16'(PWR_STANDBY), 16'(state));
		tick(POR_WAIT);
		rchk(`BLPF_ADDR_PROT, 8'h1f);
		rchk(`BLPF_ADDR_SHORT, 8'h18);
		rchk(7'h7f, 8'h00);
		for (int c = 0; c < 8; c++) begin
			wr(`BLPF_ADDR_SHORT, {5'h03, 3'(c)});
			chk(16'(c), 16'(thr));
		end
		rchk(`BLPF_ADDR_SHORT, 8'h1f);
		wr(`BLPF_ADDR_CURON_LO, 8'hff);
		wr(`BLPF_ADDR_CURON_HI, 8'hff);
		tick(20);
		chk(16'hffff, chan_on);
		duty_i = 14'd50;
		@(posedge fs);
		tick(10);
		chk(16'hffff, chan_on);
		tick(60);
		chk(16'h0000, chan_on);
		short_cmp = mask;
		tick(400);
		chk(16'h0001, 16'(fault_pin));
		duty_i = '1;
		tick(200);
		chk(16'h0000, 16'(fault_pin));
		chk(~mask, chan_on);
		rchk(`BLPF_ADDR_STATUS, 8'h05);
		rchk(`BLPF_ADDR_FLAG_LO, mask[7:0]);
		rchk(`BLPF_ADDR_FLAG_HI, mask[15:8]);
		short_cmp = '0;
		wr(`BLPF_ADDR_FLAG_LO, 8'hff);
		wr(`BLPF_ADDR_FLAG_HI, 8'hff);
		tick(20);
		chk(16'h0001, 16'(fault_pin));
		chk(16'hffff, chan_on);
		wr(`BLPF_ADDR_SHORT, 8'h10);
		short_cmp = mask;
		tick(200);
		chk(16'h0001, 16'(fault_pin));
		short_cmp = '0;
		warn = 1'b0;
		tick(30);
		chk(16'(PWR_LOW_SUPPLY), 16'(state));
		chk(16'h0000, chan_on);
		rchk(`BLPF_ADDR_CURON_LO, 8'h00);
		rchk(`BLPF_ADDR_SHORT, 8'h10);
		warn = 1'b1;
		tick(10);
		wr(`BLPF_ADDR_PROT, 8'h0f);
		wr(`BLPF_ADDR_CURON_LO, 8'hff);
		wr(`BLPF_ADDR_CURON_HI, 8'hff);
		warn = 1'b0;
		tick(30);
		chk(16'(PWR_LOW_SUPPLY), 16'(state));
		chk(16'hffff, chan_on);
		lock = 1'b0;
		tick(10);
		chk(16'(PWR_SHUTDOWN), 16'(state));
		tick(20);
		chk(16'h0000, chan_on);
		wr(`BLPF_ADDR_CURON_LO, 8'hff);
		{warn, lock} = 2'b11;
		tick(10);
		chk(16'(PWR_STANDBY), 16'(state));
		rchk(`BLPF_ADDR_CURON_LO, 8'h00);
		rchk(`BLPF_ADDR_PROT, 8'h1f);
		rchk(`BLPF_ADDR_SHORT, 8'h18);
		stop_test();
	end
endmodule
